// >>> src/stall_logic.sv
// stepper driver control: coil current select, undervoltage, back voltage, stall
// assumes pwm/zero-cross/sample strobes come from logic on clk; pins are async
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module stall_logic #(
	parameter int FAST0 = stall_pkg::FAST0_CYC,
	parameter int FAST1 = stall_pkg::FAST1_CYC
)(
	input wire logic clk,
	input wire logic rstn,
	input wire stall_pkg::apb_req_s apb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire logic advance_pin,
	input wire logic rotation_sense_pin,
	input wire logic uv_cmp,
	input wire logic thermal_warn,
	input wire logic pwm_start,
	input wire logic [1:0] zc_active,
	input wire logic [1:0] coil_on,
	input wire stall_pkg::bemf_s sample,
	output logic fault_out_o,
	output logic fault_out_oe,
	output var stall_pkg::bridge_e bridge_mode,
	output logic [10:0] peak_ma,
	output logic [5:0] position,
	output logic step_pulse
);

	// peak current tables in mA
	function automatic logic [10:0] peak_lut(input logic [3:0] s, input logic b);
		logic [10:0] n;
		logic [10:0] h;
		n = 11'd0;
		h = 11'd0;
		case (s)
			4'h0: begin n = 11'd59; h = 11'd81; end
			4'h1: begin n = 11'd71; h = 11'd98; end
			4'h2: begin n = 11'd84; h = 11'd116; end
			4'h3: begin n = 11'd100; h = 11'd138; end
			4'h4: begin n = 11'd119; h = 11'd164; end
			4'h5: begin n = 11'd141; h = 11'd194; end
			4'h6: begin n = 11'd168; h = 11'd231; end
			4'h7: begin n = 11'd200; h = 11'd275; end
			4'h8: begin n = 11'd238; h = 11'd327; end
			4'h9: begin n = 11'd283; h = 11'd389; end
			4'ha: begin n = 11'd336; h = 11'd462; end
			4'hb: begin n = 11'd400; h = 11'd550; end
			4'hc: begin n = 11'd476; h = 11'd655; end
			4'hd: begin n = 11'd566; h = 11'd778; end
			4'he: begin n = 11'd673; h = 11'd925; end
			default: begin n = 11'd800; h = 11'd1100; end
		endcase
		return b ? h : n;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers, two flops each
	logic [3:0] pin_m_r;
	logic [3:0] pin_s_r;
	logic adv_d_r;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_m_r <= 4'h0;
			pin_s_r <= 4'h0;
			adv_d_r <= 1'b0;
		end
		else
		begin
			pin_m_r <= {thermal_warn, uv_cmp, rotation_sense_pin, advance_pin};
			pin_s_r <= pin_m_r;
			adv_d_r <= pin_s_r[0];
		end
	end
	wire adv_s = pin_s_r[0];
	wire dir_pin = pin_s_r[1];
	wire uv_s = pin_s_r[2];
	wire tw_s = pin_s_r[3];

	//////////////////////////////////////////////////////////////////////////
	// apb decode; zero wait states so pready is constant high
	logic [14:0] ctrl_r;
	logic [23:0] cfg_r;
	wire acc = apb.psel && apb.penable;
	wire wr = acc && apb.pwrite;
	wire rd = acc && !apb.pwrite;
	wire hit_ctrl = apb.paddr == stall_pkg::CTRL_OFS;
	wire hit_cfg = apb.paddr == stall_pkg::CFG_OFS;
	wire hit_stat = apb.paddr == stall_pkg::STAT_OFS;
	wire hit_bemf = apb.paddr == stall_pkg::BEMF_OFS;
	wire hit_cur = apb.paddr == stall_pkg::CUR_OFS;
	wire mapped = hit_ctrl | hit_cfg | hit_stat | hit_bemf | hit_cur;
	wire rd_stat = rd && hit_stat;
	wire rd_bemf = rd && hit_bemf;
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;

	wire sleep = ctrl_r[stall_pkg::C_SLP];
	wire [3:0] thr = cfg_r[stall_pkg::F_THR +: 4];
	wire [7:0] tmo = cfg_r[stall_pkg::F_TMO +: 8];
	wire [7:0] limit = cfg_r[stall_pkg::F_LIM +: 8];

	//////////////////////////////////////////////////////////////////////////
	// step triggers and positioner
	logic uv_flag_r;
	logic blocked_r;
	logic lost_r;
	logic stall_hit;
	logic [5:0] pos_r;
	logic dir_d_r;
	logic toggled_r;
	wire dir_eff = dir_pin ^ ctrl_r[stall_pkg::C_POL];
	wire pin_edge = adv_s && !adv_d_r;
	// pin edge wins a tie; the command bit stays set and steps a cycle later
	wire trig_pin = pin_edge && !sleep;
	wire trig_cmd = ctrl_r[stall_pkg::C_ADV] && !pin_edge && !sleep;
	wire trig = trig_pin | trig_cmd;
	wire do_step = trig && !blocked_r;
	assign step_pulse = do_step;
	assign position = pos_r;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pos_r <= stall_pkg::POS_RST;
		else if (stall_hit)
			pos_r <= dir_eff ? pos_r - stall_pkg::BACK_135 : pos_r + stall_pkg::BACK_135;
		else if (do_step)
			pos_r <= dir_eff ? pos_r + 6'd1 : pos_r - 6'd1;
	end

	//////////////////////////////////////////////////////////////////////////
	// control and configuration registers
	wire en_wr_ok = !uv_flag_r;
	wire uv_deb_hit;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ctrl_r <= stall_pkg::CTRL_RST;
		else
		begin
			if (wr && hit_ctrl)
			begin
				ctrl_r <= apb.pwdata[14:0];
				ctrl_r[stall_pkg::C_EN] <= apb.pwdata[stall_pkg::C_EN] && en_wr_ok;
			end
			else if (trig_cmd)
				ctrl_r[stall_pkg::C_ADV] <= 1'b0;
			if (tw_s)
				ctrl_r[stall_pkg::C_BOOST] <= 1'b0;
			if (uv_deb_hit)
				ctrl_r[stall_pkg::C_EN] <= 1'b0;
		end
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cfg_r <= stall_pkg::CFG_RST;
		else if (wr && hit_cfg)
			cfg_r <= apb.pwdata[23:0];
	end

	//////////////////////////////////////////////////////////////////////////
	// coil current target, updated only at a pwm period boundary
	logic [10:0] peak_r;
	wire boost_on = ctrl_r[stall_pkg::C_BOOST] && !tw_s;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			peak_r <= 11'd0;
		else if (pwm_start)
			peak_r <= peak_lut(ctrl_r[stall_pkg::C_ISEL +: 4], boost_on);
	end
	assign peak_ma = peak_r;

	//////////////////////////////////////////////////////////////////////////
	// undervoltage debounce counted in pwm periods
	logic [7:0] deb_r;
	logic uvw_r;
	wire [1:0] dsel = ctrl_r[stall_pkg::C_DEB +: 2];
	wire [7:0] deb_lim = dsel == 2'd0 ? stall_pkg::DEB_P0 : dsel == 2'd1 ? stall_pkg::DEB_P1 :
		dsel == 2'd2 ? stall_pkg::DEB_P2 : stall_pkg::DEB_P3;
	assign uv_deb_hit = uv_s && pwm_start && deb_r >= deb_lim;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			deb_r <= 8'h00;
		else if (!uv_s)
			deb_r <= 8'h00;
		else if (pwm_start && deb_r != 8'hff)
			deb_r <= deb_r + 8'h01;
	end
	// status flags: set wins; a read clears only the bits it reported, so a
	// flag raised after the setup-phase capture is not lost
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			uvw_r <= 1'b0;
			uv_flag_r <= 1'b0;
			lost_r <= 1'b0;
		end
		else
		begin
			uvw_r <= uv_s | (uvw_r & !(rd_stat && prdata[0]));
			uv_flag_r <= uv_deb_hit | (uv_flag_r & !(rd_stat && prdata[1] && !uv_s));
			lost_r <= (trig && uv_s) | (lost_r & !(rd_stat && prdata[2]));
		end
	end
	// undervoltage reaction after sleep, ahead of enable: the flag clears drive enable, brake must survive that
	assign bridge_mode = sleep ? stall_pkg::BR_HIZ :
		uv_flag_r ? (ctrl_r[stall_pkg::C_ACT] ? stall_pkg::BR_BRAKE : stall_pkg::BR_HIZ) :
		ctrl_r[stall_pkg::C_EN] ? stall_pkg::BR_DRIVE : stall_pkg::BR_HIZ;

	//////////////////////////////////////////////////////////////////////////
	// step interval in 20 us ticks, and fast-step guard
	logic [11:0] tick_r;
	logic [7:0] ivl_cnt_r;
	logic [7:0] ivl_r;
	logic [13:0] gap_r;
	wire tick = tick_r == 12'(stall_pkg::TICK_CYC - 1);
	wire [13:0] fast_lim = ctrl_r[stall_pkg::C_JIT] ? 14'(FAST1) : 14'(FAST0);
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tick_r <= 12'h000;
			ivl_cnt_r <= 8'h00;
			ivl_r <= 8'hff;
			gap_r <= 14'h0000;
		end
		else
		begin
			tick_r <= (tick || do_step) ? 12'h000 : tick_r + 12'h001;
			if (do_step)
			begin
				ivl_r <= ivl_cnt_r;
				ivl_cnt_r <= 8'h00;
				gap_r <= 14'h0000;
			end
			else
			begin
				if (tick && ivl_cnt_r != 8'hff)
					ivl_cnt_r <= ivl_cnt_r + 8'h01;
				if (gap_r != 14'h3fff)
					gap_r <= gap_r + 14'h0001;
			end
		end
	end
	wire slow_ok = ivl_r <= limit;
	// gap held from the previous step pair; a fast pair blocks detection
	logic fast_r;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			fast_r <= 1'b0;
		else if (do_step)
			fast_r <= gap_r < fast_lim;
	end

	//////////////////////////////////////////////////////////////////////////
	// back voltage sampling and publication
	logic [1:0] zc_d_r;
	logic [4:0] last_r;
	logic last_sgn_r;
	logic last_coil_r;
	logic have_r;
	logic [4:0] code_r;
	logic sgn_r;
	logic coil_r;
	logic ready_r;
	logic [9:0] tmo_r;
	logic tmo_done_r;
	wire zc_any = |zc_active;
	wire zc_end = |(zc_d_r & ~zc_active);
	// drop samples while the other coil's switches are on
	wire keep = sample.valid && zc_active[sample.coil] && !coil_on[!sample.coil] && slow_ok;
	wire tmo_fire = zc_any && tmo != 8'h00 && !tmo_done_r && pwm_start &&
		tmo_r + 10'd1 >= {tmo, 2'b00};
	wire eval = (zc_end || tmo_fire) && have_r;
	wire publish = ctrl_r[stall_pkg::C_ENH] ? keep : eval;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			zc_d_r <= 2'b00;
			tmo_r <= 10'h000;
			tmo_done_r <= 1'b0;
		end
		else
		begin
			zc_d_r <= zc_active;
			if (!zc_any || zc_end)
			begin
				tmo_r <= 10'h000;
				tmo_done_r <= 1'b0;
			end
			else if (pwm_start)
			begin
				tmo_r <= tmo_r + 10'd1;
				tmo_done_r <= tmo_done_r | tmo_fire;
			end
		end
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			last_r <= 5'h00;
			last_sgn_r <= 1'b0;
			last_coil_r <= 1'b0;
			have_r <= 1'b0;
		end
		else if (keep)
		begin
			last_r <= sample.code;
			last_sgn_r <= sample.sign_bad;
			last_coil_r <= sample.coil;
			have_r <= 1'b1;
		end
		else if (eval)
			have_r <= 1'b0;
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			code_r <= 5'h00;
			sgn_r <= 1'b0;
			coil_r <= 1'b0;
		end
		else if (publish)
		begin
			code_r <= ctrl_r[stall_pkg::C_ENH] ? sample.code : last_r;
			sgn_r <= ctrl_r[stall_pkg::C_ENH] ? sample.sign_bad : last_sgn_r;
			coil_r <= ctrl_r[stall_pkg::C_ENH] ? sample.coil : last_coil_r;
		end
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ready_r <= 1'b0;
		else
			ready_r <= publish | (ready_r & !(rd_bemf && prdata[7]));
	end

	//////////////////////////////////////////////////////////////////////////
	// stall detection on the last sample of each crossing
	logic [1:0] hits_r;
	wire low = last_r[4:1] < thr;
	wire armed = thr != 4'h0 && slow_ok && !fast_r && !blocked_r;
	assign stall_hit = eval && armed && low && hits_r == 2'(stall_pkg::STALL_HITS - 1);
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			hits_r <= 2'd0;
		else if (eval)
			hits_r <= (armed && low && !stall_hit) ? hits_r + 2'd1 : 2'd0;
	end
	// a direction change must be seen before the status read frees the rotor
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			blocked_r <= 1'b0;
			toggled_r <= 1'b0;
			dir_d_r <= 1'b0;
		end
		else
		begin
			dir_d_r <= dir_eff;
			if (stall_hit)
			begin
				blocked_r <= 1'b1;
				toggled_r <= 1'b0;
			end
			else
			begin
				if (blocked_r && dir_eff != dir_d_r)
					toggled_r <= 1'b1;
				if (rd_stat && toggled_r && prdata[3])
					blocked_r <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// fault pin, open drain, released in sleep
	wire fault = (uv_flag_r | blocked_r | tw_s) && !sleep;
	assign fault_out_o = 1'b0;
	assign fault_out_oe = fault;

	//////////////////////////////////////////////////////////////////////////
	// read data captured in the setup phase
	wire [31:0] rmux = hit_ctrl ? {17'h0, ctrl_r} :
		hit_cfg ? {8'h0, cfg_r} :
		hit_stat ? {26'h0, boost_on, tw_s, blocked_r, lost_r, uv_flag_r, uvw_r} :
		hit_bemf ? {9'h0, dir_eff, pos_r, ivl_r, ready_r, coil_r, sgn_r, code_r} :
		hit_cur ? {20'h0, boost_on, peak_r} : 32'h0;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			prdata <= 32'h0;
		else if (apb.psel && !apb.penable)
			prdata <= rmux;
	end

endmodule

`default_nettype wire

// >>> src/stall_pkg.sv
// package: register map, field positions, timing constants and carrier types
// assumes a 125 MHz clock and an apb master with 32-bit data
package stall_pkg;

	localparam int CLK_MHZ = 125;
	// apb byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] CFG_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] BEMF_OFS = 8'h0c;
	localparam logic [7:0] CUR_OFS = 8'h10;
	// control register fields
	localparam int C_ISEL = 0;
	localparam int C_BOOST = 4;
	localparam int C_EN = 5;
	localparam int C_ADV = 6;
	localparam int C_POL = 7;
	localparam int C_DEB = 8;
	localparam int C_ACT = 10;
	localparam int C_ENH = 11;
	localparam int C_JIT = 12;
	localparam int C_GAIN = 13;
	localparam int C_SLP = 14;
	// configuration register fields
	localparam int F_TMO = 0;
	localparam int F_THR = 8;
	localparam int F_LIM = 16;
	// reset values
	localparam logic [14:0] CTRL_RST = 15'h0000;
	localparam logic [23:0] CFG_RST = 24'hff0000;
	localparam logic [5:0] POS_RST = 6'h08;
	// timing
	localparam int TICK_NS = 20000;
	localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;
	// fast-step guard gaps in ns, rounded up to whole clock cycles
	localparam int FAST0_NS = 74500;
	localparam int FAST1_NS = 80000;
	localparam int FAST0_CYC = (FAST0_NS * CLK_MHZ + 999) / 1000;
	localparam int FAST1_CYC = (FAST1_NS * CLK_MHZ + 999) / 1000;
	localparam int TMO_UNIT = 4;
	localparam int STALL_HITS = 2;
	localparam logic [5:0] BACK_135 = 6'd24;
	// undervoltage debounce, in pwm periods per selector value
	localparam logic [7:0] DEB_P0 = 8'h01;
	localparam logic [7:0] DEB_P1 = 8'h04;
	localparam logic [7:0] DEB_P2 = 8'h10;
	localparam logic [7:0] DEB_P3 = 8'h40;

	typedef enum logic [1:0] {BR_HIZ, BR_DRIVE, BR_BRAKE} bridge_e;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	// one back voltage conversion from the analog front end
	typedef struct packed {
		logic valid;
		logic coil;
		logic sign_bad;
		logic [4:0] code;
	} bemf_s;

endpackage

// >>> tb/mcu_model.sv
// partner: microcontroller side, apb master transfers and step/direction pins
// assumes answers are sampled on rising edges only; waits end by bench timeout
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
	input wire logic clk,
	input wire logic pready,
	output var stall_pkg::apb_req_s apb,
	output logic advance_pin,
	output logic rotation_sense_pin
);
	// expected reads: {slave error, mask, value}
	logic [64:0] exp_q[$];

	//////////////////////////////////////////////////////////////////////////////
	// idle levels at time zero
	initial
	begin
		apb = '0;
		advance_pin = 1'b0;
		rotation_sense_pin = 1'b0;
	end

	// one transfer, idle cycle after so no signal is assigned twice per step
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		apb <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		apb.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		apb <= '0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, input logic e);
		exp_q.push_back({e, m, v});
		xfer(1'b0, a, 32'h0);
	endtask

	// direction settles before the rising edge; gap sets the step rate
	task automatic step(input logic dir, input int gap);
		rotation_sense_pin <= dir;
		repeat (3) @(posedge clk);
		advance_pin <= 1'b1;
		repeat (gap) @(posedge clk);
		advance_pin <= 1'b0;
		repeat (gap) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// >>> tb/stall_monitor.sv
// checker: port-level timing relations of the stall and current block
// assumes it is bound to the block top, with the same port names
`timescale 1ns/1ps
`default_nettype none
module stall_monitor (
	input wire logic clk,
	input wire logic rstn,
	input wire stall_pkg::apb_req_s apb,
	input wire logic pslverr,
	input wire logic thermal_warn,
	input wire logic pwm_start,
	input wire logic fault_out_oe,
	input wire stall_pkg::bridge_e bridge_mode,
	input wire logic [10:0] peak_ma,
	input wire logic [5:0] position,
	input wire logic step_pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic sleep_r;
	logic en_r;
	wire ctrl_wr = apb.psel && apb.penable && apb.pwrite && apb.paddr == stall_pkg::CTRL_OFS;

	//////////////////////////////////////////////////////////////////////////////
	// shadow bits; shadow enable may be 1 where the block refused it, still safe
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			sleep_r <= 1'b0;
			en_r <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			sleep_r <= apb.pwdata[stall_pkg::C_SLP];
			en_r <= apb.pwdata[stall_pkg::C_EN];
		end

	// named steps of the longer behaviours
	sequence warm_s;
		thermal_warn [*5] ##0 pwm_start;
	endsequence
	sequence lone_move_s;
		$changed(position) && !$past(step_pulse);
	endsequence

	step_move_a: assert property (
		step_pulse |=> 6'(position - $past(position)) inside {6'h01, 6'h3f})
		else $error("step moved position by other than one");
	back_jump_a: assert property (
		lone_move_s |-> position == $past(position) - stall_pkg::BACK_135 && fault_out_oe)
		else $error("stall jump wrong or fault not driven");
	cur_update_a: assert property (
		$changed(peak_ma) |-> $past(pwm_start))
		else $error("peak current changed outside pwm start");
	thermal_drop_a: assert property (
		warm_s |=> peak_ma <= 11'd800)
		else $error("boost current kept while warm");
	peak_limit_a: assert property (
		peak_ma <= 11'd1100)
		else $error("peak current above table");
	brake_fault_a: assert property (
		bridge_mode == stall_pkg::BR_BRAKE |-> fault_out_oe)
		else $error("brake without fault output");
	drive_off_a: assert property (
		!en_r |-> bridge_mode != stall_pkg::BR_DRIVE)
		else $error("bridges driven while disabled");
	sleep_still_a: assert property (
		sleep_r |-> !step_pulse)
		else $error("step taken in sleep");
	unmapped_err_a: assert property (
		apb.psel && apb.penable && apb.paddr > stall_pkg::CUR_OFS |-> pslverr)
		else $error("unmapped access without slave error");
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// bench top: current table, steps, back voltage, stall, undervoltage
// assumes the partner model drives apb and the pins; analog strobes made here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, rstn, thermal_warn, uv_cmp, pready, pslverr;
	logic advance_pin, rotation_sense_pin, fault_out_o, fault_out_oe, step_pulse;
	logic pwm_start = 1'b0;
	logic [3:0] pc = 4'h0;
	logic [1:0] zc_active, coil_on;
	logic [31:0] prdata, v;
	logic [10:0] peak_ma, pk_e;
	logic [5:0] position;
	logic [64:0] e;
	stall_pkg::bemf_s sample;
	stall_pkg::apb_req_s apb;
	stall_pkg::bridge_e bridge_mode;
	logic [10:0] ua[16] = '{59, 71, 84, 100, 119, 141, 168, 200, 238, 283, 336, 400, 476, 566, 673, 800};
	logic [10:0] ba[16] = '{81, 98, 116, 138, 164, 194, 231, 275, 327, 389, 462, 550, 655, 778, 925, 1100};
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int seed = 32'h5b884bdb;

	stall_logic #(.FAST0(20), .FAST1(25)) dut (.clk, .rstn, .apb, .pready, .pslverr, .prdata,
		.advance_pin, .rotation_sense_pin, .uv_cmp, .thermal_warn, .pwm_start, .zc_active, .coil_on,
		.sample, .fault_out_o, .fault_out_oe, .bridge_mode, .peak_ma, .position, .step_pulse);
	mcu_model mcu (.clk, .pready, .apb, .advance_pin, .rotation_sense_pin);

	//////////////////////////////////////////////////////////////////////////////
	// clock, pwm strobe every 16 cycles, hang limit
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
	begin
		pc <= pc + 4'h1;
		pwm_start <= pc == 4'hf;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			print_verdict();
		end
	end

	// oldest note against each completed read
	always @(posedge clk)
		if (apb.psel && apb.penable && !apb.pwrite && pready === 1'b1)
		begin
			e = mcu.exp_q.pop_front();
			cmp("prdata", prdata & e[63:32], e[31:0]);
			cmp("pslverr", 32'(pslverr), 32'(e[64]));
		end

	task automatic cmp(input string nm, input logic [31:0] got, input logic [31:0] x);
		n_compared++;
		if (got !== x)
		begin
			$display("unexpected %s expected %h seen %h", nm, x, got);
			errors++;
		end
	endtask
	task automatic cpos(input logic [5:0] p);
		repeat (3) @(posedge clk);
		cmp("position", 32'(position), 32'(p));
	endtask
	task automatic cflt(input logic f);
		cmp("fault_out_oe", 32'(fault_out_oe), 32'(f));
		cmp("fault_out_o", 32'(fault_out_o), 32'h0);
	endtask
	task automatic wc(input logic [31:0] d);
		mcu.xfer(1'b1, stall_pkg::CTRL_OFS, d);
	endtask
	// one zero crossing sample; sign flag set for coil 1 samples
	task automatic xing(input logic c, input logic [4:0] code, input logic other);
		zc_active[c] <= 1'b1;
		coil_on[!c] <= other;
		@(posedge clk);
		sample <= '{1'b1, c, c, code};
		@(posedge clk);
		sample <= '0;
		coil_on <= '0;
		repeat (2) @(posedge clk);
	endtask
	task automatic zc_end();
		zc_active <= '0;
		repeat (3) @(posedge clk);
	endtask
	task automatic print_verdict();
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		rstn = 1'b0;
		thermal_warn = 1'b0;
		uv_cmp = 1'b0;
		zc_active = '0;
		coil_on = '0;
		sample = '0;
		pk_e = ua[0];
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		mcu.rd(stall_pkg::CTRL_OFS, 32'hffffffff, 32'h0, 1'b0);
		mcu.rd(stall_pkg::CFG_OFS, 32'hffffffff, 32'h00ff0000, 1'b0);
		mcu.rd(8'h20, 32'hffffffff, 32'h0, 1'b1);
		cpos(6'h08);
		for (int k = 0; k < 32; k++)
		begin
			@(posedge clk iff pwm_start);
			wc(32'(k));
			cmp("peak_ma", 32'(peak_ma), 32'(pk_e));
			@(posedge clk iff pwm_start);
			@(posedge clk);
			pk_e = k[4] ? ba[k[3:0]] : ua[k[3:0]];
			cmp("peak_ma", 32'(peak_ma), 32'(pk_e));
		end
		thermal_warn <= 1'b1;
		repeat (40) @(posedge clk);
		cmp("peak_ma", 32'(peak_ma), 32'd800);
		mcu.rd(stall_pkg::STAT_OFS, 32'h30, 32'h10, 1'b0);
		thermal_warn <= 1'b0;
		wc(32'h40);
		cpos(6'h07);
		cmp("bridge_mode", 32'(bridge_mode), 32'(stall_pkg::BR_HIZ));
		mcu.step(1'b1, 4);
		cpos(6'h08);
		wc(32'hc0);
		cpos(6'h07);
		wc(32'h4000);
		mcu.step(1'b0, 4);
		cpos(6'h07);
		wc(32'h0);
		xing(1'b0, 5'h15, 1'b0);
		mcu.rd(stall_pkg::BEMF_OFS, 32'h1f, 32'h0, 1'b0);
		zc_end();
		mcu.rd(stall_pkg::BEMF_OFS, 32'hff, 32'h95, 1'b0);
		wc(32'h800);
		xing(1'b1, 5'h0b, 1'b0);
		mcu.rd(stall_pkg::BEMF_OFS, 32'h7f, 32'h6b, 1'b0);
		xing(1'b1, 5'h1e, 1'b1);
		mcu.rd(stall_pkg::BEMF_OFS, 32'h1f, 32'h0b, 1'b0);
		zc_end();
		cflt(1'b0);
		mcu.xfer(1'b1, stall_pkg::CFG_OFS, 32'h00ff0400);
		wc(32'h0);
		mcu.step(1'b1, 40);
		mcu.step(1'b1, 40);
		for (int z = 0; z < 2; z++)
		begin
			xing(z[0], 5'($random(seed)) & 5'h07, 1'b0);
			zc_end();
		end
		cpos(6'd49);
		cflt(1'b1);
		mcu.step(1'b1, 4);
		cpos(6'd49);
		mcu.rd(stall_pkg::STAT_OFS, 32'h8, 32'h8, 1'b0);
		mcu.step(1'b0, 4);
		mcu.rd(stall_pkg::STAT_OFS, 32'h8, 32'h8, 1'b0);
		mcu.rd(stall_pkg::STAT_OFS, 32'h8, 32'h0, 1'b0);
		cflt(1'b0);
		mcu.step(1'b0, 4);
		cpos(6'd48);
		for (int i = 0; i < 2; i++)
		begin
			v = 32'h20 | (32'(i) << 10) | (32'(i) << 8);
			wc(v);
			cmp("bridge_mode", 32'(bridge_mode), 32'(stall_pkg::BR_DRIVE));
			uv_cmp <= 1'b1;
			repeat (40) @(posedge clk);
			cflt(i == 0);
			repeat (60) @(posedge clk);
			cflt(1'b1);
			cmp("bridge_mode", 32'(bridge_mode), 32'(i ? stall_pkg::BR_BRAKE : stall_pkg::BR_HIZ));
			wc(v | 32'h40);
			mcu.rd(stall_pkg::CTRL_OFS, 32'h20, 32'h0, 1'b0);
			mcu.rd(stall_pkg::STAT_OFS, 32'h7, 32'h7, 1'b0);
			uv_cmp <= 1'b0;
			repeat (10) @(posedge clk);
			mcu.rd(stall_pkg::STAT_OFS, 32'h7, 32'h3, 1'b0);
			mcu.rd(stall_pkg::STAT_OFS, 32'h7, 32'h0, 1'b0);
		end
		// close steps keep stall detection off
		mcu.xfer(1'b1, stall_pkg::CFG_OFS, 32'h00ff0400);
		mcu.step(1'b1, 4);
		mcu.step(1'b1, 4);
		for (int z = 0; z < 2; z++)
		begin
			xing(z[0], 5'h03, 1'b0);
			zc_end();
		end
		cflt(1'b0);
		// a crossing that never ends is evaluated at the timeout
		mcu.xfer(1'b1, stall_pkg::CFG_OFS, 32'h00ff0001);
		xing(1'b0, 5'h19, 1'b0);
		repeat (80) @(posedge clk);
		mcu.rd(stall_pkg::BEMF_OFS, 32'h1f, 32'h19, 1'b0);
		zc_end();
		// step interval above a zero limit discards samples
		mcu.xfer(1'b1, stall_pkg::CFG_OFS, 32'h0);
		repeat (2600) @(posedge clk);
		mcu.step(1'b1, 4);
		xing(1'b0, 5'h1d, 1'b0);
		zc_end();
		mcu.rd(stall_pkg::BEMF_OFS, 32'hff1f, 32'h0119, 1'b0);
		print_verdict();
	end
endmodule

bind stall_logic stall_monitor mon (.clk, .rstn, .apb, .pslverr, .thermal_warn, .pwm_start,
	.fault_out_oe, .bridge_mode, .peak_ma, .position, .step_pulse);
`default_nettype wire
